// ==== logic/cam_pkg.sv ====
// Package for the clock accuracy monitor: selector encodings, field layouts and reset values.
// Assumes a single ref_clk domain; measured and reference clocks arrive as asynchronous levels.
package cam_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // Measurement prescaler selector: 0 -> /1, 1 -> /4, 2 -> /8, 3 -> /32.
  localparam logic [1:0] MDIV_1 = 2'h0;
  localparam logic [1:0] MDIV_4 = 2'h1;
  localparam logic [1:0] MDIV_8 = 2'h2;
  localparam logic [1:0] MDIV_32 = 2'h3;
  // Reference divider selector: 0 -> /32, 1 -> /128, 2 -> /1024, 3 -> /8192.
  localparam logic [1:0] RDIV_32 = 2'h0;
  localparam logic [1:0] RDIV_128 = 2'h1;
  localparam logic [1:0] RDIV_1024 = 2'h2;
  localparam logic [1:0] RDIV_8192 = 2'h3;
  // Edge selector.
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // Filter selector: 0 off, 1 every cycle, 2 every 4th, 3 every 16th sample.
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam int FILT_LEN = 3;

  typedef struct packed {
    logic        repeat_mode;
    logic        ext_ref;
    logic [1:0]  mdiv;
    logic [1:0]  rdiv;
    logic [1:0]  edge_sel;
    logic [1:0]  filt;
    logic        ferr_ie;
    logic        ovf_ie;
    logic        mend_ie;
    logic [15:0] upper;
    logic [15:0] lower;
  } cam_cfg_t;

  typedef struct packed {
    logic ovf;
    logic ferr;
    logic mend;
  } cam_flags_t;
endpackage : cam_pkg

// ==== logic/cam_div.sv ====
// Programmable divider producing a one-cycle enable on every Nth rising edge of a synchronised clock.
// Assumes clk_in is already synchronised to ref_clk; the ratio may change only while idle.
module cam_div
  import cam_pkg::*;
(
  input  wire logic        ref_clk,  // System clock.
  input  wire logic        rst,      // Asynchronous reset, active high.
  input  wire logic        clk_in,   // Synchronised clock level.
  input  wire logic [12:0] ratio_m1, // Division ratio minus one.
  output logic             tick,     // Pulse on each divided period.
  output logic             level     // Divided square-ish level.
);
  logic        prev;
  logic [12:0] cnt;

  // Count input rising edges; ratio one gives a tick on every edge.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prev  <= 1'b0;
      cnt   <= 13'h0000;
      tick  <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      prev <= clk_in;
      tick <= 1'b0;
      if (clk_in && !prev)
      begin
        if (cnt >= ratio_m1)
        begin
          cnt   <= 13'h0000;
          tick  <= 1'b1;
          level <= ~level;
        end
        else
          cnt <= cnt + 13'h0001;
      end
    end
  end
endmodule : cam_div

// ==== logic/cam_monitor.sv ====
// Clock accuracy monitor: counts divided measurement-clock periods between two valid reference edges.
// Assumes both clocks are far slower than ref_clk; configuration is stable while measuring.
module cam_monitor
  import cam_pkg::*;
(
  input  wire logic       ref_clk,   // System clock, 100 MHz.
  input  wire logic       rst,       // Asynchronous reset, active high.
  input  wire logic       meas_clk,  // Selected clock under measurement, asynchronous.
  input  wire logic       int_ref,   // Selected internal reference clock, asynchronous.
  input  wire logic       ext_ref,   // External reference pin, asynchronous.
  input  wire cam_cfg_t   cfg,       // Configuration bits.
  input  wire logic       start,     // Pulse: begin measuring.
  input  wire logic       stop,      // Pulse: halt measuring.
  input  wire cam_flags_t clr,       // Pulses: clear the matching flags.
  output cam_flags_t      flags,     // Sticky event flags.
  output logic [15:0]     count,     // Present counter value.
  output logic            measuring, // High while a measurement is active.
  output logic            irq_ferr,  // Frequency error interrupt.
  output logic            irq_ovf,   // Overflow interrupt.
  output logic            irq_mend   // Measurement end interrupt.
);
  typedef enum logic [1:0] {CAM_IDLE, CAM_WAIT, CAM_COUNT} cam_state_t;

  cam_state_t  state;
  logic [1:0]  ms_sync, ir_sync, er_sync; // Two-stage synchronisers; bit 1 is the safe tap.
  logic        ms_s, ir_s, er_s;
  logic        m_tick, r_tick, r_level;
  logic [12:0] m_ratio, r_ratio;
  logic [3:0]  samp_cnt;
  logic [FILT_LEN-2:0] filt_sh; // Earlier samples; the newest one is er_s itself.
  logic        ref_f, ref_prev, ref_edge;
  logic        done;
  logic        in_range;

  // Synchronise the three asynchronous clock levels before anything looks at them.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ms_sync <= 2'h0;
      ir_sync <= 2'h0;
      er_sync <= 2'h0;
    end
    else
    begin
      ms_sync <= {ms_sync[0], meas_clk};
      ir_sync <= {ir_sync[0], int_ref};
      er_sync <= {er_sync[0], ext_ref};
    end
  end
  assign ms_s = ms_sync[1];
  assign ir_s = ir_sync[1];
  assign er_s = er_sync[1];

  // Prescaler ratios decoded from the selectors.
  always_comb
  begin
    case (cfg.mdiv)
      MDIV_1:  m_ratio = 13'h0000;
      MDIV_4:  m_ratio = 13'h0003;
      MDIV_8:  m_ratio = 13'h0007;
      default: m_ratio = 13'h001F;
    endcase
    case (cfg.rdiv)
      RDIV_32:   r_ratio = 13'h001F;
      RDIV_128:  r_ratio = 13'h007F;
      RDIV_1024: r_ratio = 13'h03FF;
      default:   r_ratio = 13'h1FFF;
    endcase
  end

  cam_div u_mdiv (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_in   (ms_s),
    .ratio_m1 (m_ratio),
    .tick     (m_tick),
    .level    ()
  );

  // The internal reference divider output toggles, so halve the ratio to keep a full period per N.
  cam_div u_rdiv (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_in   (ir_s),
    .ratio_m1 ({1'b0, r_ratio[12:1]}),
    .tick     (r_tick),
    .level    (r_level)
  );

  // Digital filter on the external reference: accept a level only after FILT_LEN equal samples.
  // Sampling is paced by the measured clock, so a slow measured clock also slows the filter.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      samp_cnt <= 4'h0;
      filt_sh  <= '0;
      ref_f    <= 1'b0;
    end
    else if (cfg.filt == FILT_OFF)
    begin
      ref_f <= cfg.ext_ref ? er_s : r_level;
    end
    else if (!cfg.ext_ref)
    begin
      ref_f <= r_level;
    end
    else if (m_tick)
    begin
      samp_cnt <= samp_cnt + 4'h1;
      if ((cfg.filt == 2'h1) || (cfg.filt == 2'h2 && samp_cnt[1:0] == 2'h3) || (samp_cnt == 4'hF))
      begin
        filt_sh <= {filt_sh[FILT_LEN-3:0], er_s};
        if (&{filt_sh, er_s})
          ref_f <= 1'b1;
        else if (~|{filt_sh, er_s})
          ref_f <= 1'b0;
      end
    end
  end

  // Valid-edge detection on the conditioned reference.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ref_prev <= 1'b0;
    else
      ref_prev <= ref_f;
  end
  always_comb
  begin
    case (cfg.edge_sel)
      EDGE_RISE: ref_edge = ref_f && !ref_prev;
      EDGE_FALL: ref_edge = !ref_f && ref_prev;
      default:   ref_edge = ref_f != ref_prev;
    endcase
  end

  assign done     = (state == CAM_COUNT) && ref_edge;
  assign in_range = (count <= cfg.upper) && (count >= cfg.lower);

  // Measurement sequencer.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state <= CAM_IDLE;
    else if (stop)
      state <= CAM_IDLE;
    else
    begin
      case (state)
        CAM_IDLE:
          if (start)
            state <= CAM_WAIT;
        CAM_WAIT:
          if (ref_edge)
            state <= CAM_COUNT;
        CAM_COUNT:
          if (ref_edge)
            state <= cfg.repeat_mode ? CAM_COUNT : CAM_IDLE;
        default:
          state <= CAM_IDLE;
      endcase
    end
  end
  assign measuring = (state != CAM_IDLE);

  // Counter: cleared when a window opens; the closing edge reopens it in repeat mode.
  // Counting the same cycle as the edge would bias by one, so the edge cycle loads zero.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      count <= CNT_RESET;
    else if ((state == CAM_WAIT && ref_edge) || (done && cfg.repeat_mode))
      count <= CNT_RESET;
    else if (state == CAM_COUNT && m_tick)
      count <= count + 16'h0001;
  end

  // Sticky flags; a hardware set wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      flags <= '0;
    else
    begin
      if (state == CAM_COUNT && m_tick && count == CNT_MAX && !done)
        flags.ovf <= 1'b1;
      else if (clr.ovf)
        flags.ovf <= 1'b0;
      if (done && !in_range)
        flags.ferr <= 1'b1;
      else if (clr.ferr)
        flags.ferr <= 1'b0;
      if (done && in_range)
        flags.mend <= 1'b1;
      else if (clr.mend)
        flags.mend <= 1'b0;
    end
  end

  // Interrupt lines follow flags only when enabled; flags are kept regardless.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_ferr <= 1'b0;
      irq_ovf  <= 1'b0;
      irq_mend <= 1'b0;
    end
    else
    begin
      irq_ferr <= flags.ferr && cfg.ferr_ie;
      irq_ovf  <= flags.ovf && cfg.ovf_ie;
      irq_mend <= flags.mend && cfg.mend_ie;
    end
  end

  chk_single_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (done && !cfg.repeat_mode && !stop) |=> !measuring) else $error("single shot did not stop");
  chk_repeat_run: assert property (@(posedge ref_clk) disable iff (rst)
    (done && cfg.repeat_mode && !stop) |=> measuring && count == 16'h0000) else $error("repeat lost");
  chk_ferr_set: assert property (@(posedge ref_clk) disable iff (rst)
    (done && !in_range) |=> flags.ferr) else $error("ferr not set");
  chk_mend_set: assert property (@(posedge ref_clk) disable iff (rst)
    (done && in_range && !flags.ferr) |=> flags.mend && !flags.ferr) else $error("mend wrong");
  chk_ovf_set: assert property (@(posedge ref_clk) disable iff (rst)
    (state == CAM_COUNT && m_tick && count == 16'hFFFF && !done) |=> flags.ovf && count == 16'h0000)
    else $error("ovf not set");
  chk_flag_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (flags.mend && !clr.mend) |=> flags.mend) else $error("mend dropped");
  chk_irq_gate: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 irq_ferr == $past(flags.ferr && cfg.ferr_ie)) else $error("ferr irq gating");
  chk_clear_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (clr.ferr && !done) |=> !flags.ferr) else $error("ferr not cleared");
  chk_range_edge: assert property (@(posedge ref_clk) disable iff (rst)
    (done && count == cfg.upper) |=> flags.mend) else $error("upper bound not inclusive");
  chk_idle_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (state == CAM_IDLE && !start) |=> !measuring) else $error("self start");

  cov_single: cover property (@(posedge ref_clk) disable iff (rst) done && !cfg.repeat_mode);
  cov_repeat: cover property (@(posedge ref_clk) disable iff (rst) done && cfg.repeat_mode);
  cov_ferr: cover property (@(posedge ref_clk) disable iff (rst) done && !in_range);
  cov_ovf: cover property (@(posedge ref_clk) disable iff (rst) $rose(flags.ovf));
endmodule : cam_monitor

// ==== test/cam_clk_src.sv ====
// Behavioural model of the clock sources at the monitor's far side.
// Assumes a 10 ns system clock; odd offsets keep edges away from its sampling edges.
module cam_clk_src
#(
  parameter int MEAS_HALF = 40,  // Half period of the measured clock in ns.
  parameter int INT_HALF  = 40,  // Half period of the internal reference in ns.
  parameter int REF_HALF  = 1280 // Half period of the external reference in ns.
)
(
  output logic meas_clk, // Clock under measurement.
  output logic int_ref,  // Internal reference source.
  output logic ext_ref   // External reference pin.
);
  timeunit 1ns;
  timeprecision 100ps;

  // Oscillators run free, as real sources do; a slow source is just a larger half period.
  initial
  begin
    meas_clk = 1'b0;
    #2.3;
    forever #(MEAS_HALF) meas_clk = ~meas_clk;
  end

  initial
  begin
    int_ref = 1'b0;
    #3.7;
    forever #(INT_HALF) int_ref = ~int_ref;
  end

  initial
  begin
    ext_ref = 1'b0;
    #7.1;
    forever #(REF_HALF) ext_ref = ~ext_ref;
  end
endmodule : cam_clk_src

// ==== test/test_cam_monitor.sv ====
// Self-checking bench for the clock accuracy monitor with free-running clock sources.
// Assumes a 2560 ns reference period and an 80 ns measured clock, so a /1 count is 32.
module test_cam_monitor
  import cam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk, rst, meas_clk, int_ref, ext_ref, start, stop;
  logic        measuring, irq_ferr, irq_ovf, irq_mend;
  cam_cfg_t    cfg;
  cam_flags_t  clr, flags;
  logic [15:0] count;
  int          error_cnt, checks, cycles;

  cam_clk_src #(.MEAS_HALF(40), .INT_HALF(40), .REF_HALF(1280)) src
  (.meas_clk(meas_clk), .int_ref(int_ref), .ext_ref(ext_ref));

  cam_monitor dut
  (.ref_clk(ref_clk), .rst(rst), .meas_clk(meas_clk), .int_ref(int_ref), .ext_ref(ext_ref),
   .cfg(cfg), .start(start), .stop(stop), .clr(clr), .flags(flags), .count(count),
   .measuring(measuring), .irq_ferr(irq_ferr), .irq_ovf(irq_ovf), .irq_mend(irq_mend));

  // System clock and the hang guard; the ceiling is more than three times the expected run.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_bit

  // Sync stages shift each window end by a cycle, so one count either way is allowed.
  task automatic cmp_near(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if ((^got === 1'bx) || (got + 16'h1 < exp) || (got > exp + 16'h1))
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_near

  function automatic cam_cfg_t mk(input logic [1:0] md, input logic [1:0] es, input logic [15:0] lo,
                                  input logic [15:0] hi);
    cam_cfg_t c;
    c = '0;
    c.ext_ref = 1'b1;
    c.mdiv = md;
    c.edge_sel = es;
    c.ferr_ie = 1'b1;
    c.mend_ie = 1'b1;
    c.ovf_ie = 1'b1;
    c.lower = lo;
    c.upper = hi;
    return c;
  endfunction : mk

  // Starts one measurement, polls status, and judges count, flags and interrupts.
  task automatic run_chk(input cam_cfg_t c, input logic [15:0] exp, input logic ok);
    int n;
    @(negedge ref_clk);
    cfg = c;
    // A source switch can look like a reference edge, so let it settle before starting.
    repeat (4) @(negedge ref_clk);
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    cmp_bit("measuring", 1'b1, measuring);
    n = 0;
    while (flags.mend !== 1'b1 && flags.ferr !== 1'b1 && n < 4000)
    begin
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
    cmp_near("count", c.repeat_mode ? 16'h0 : exp, count);
    cmp_bit("mend", ok, flags.mend);
    cmp_bit("ferr", !ok, flags.ferr);
    cmp_bit("irq_mend", ok & c.mend_ie, irq_mend);
    cmp_bit("irq_ferr", !ok & c.ferr_ie, irq_ferr);
    cmp_bit("ovf", 1'b0, flags.ovf | irq_ovf);
  endtask : run_chk

  // Software order: stop first, then clear, so no event can slip in.
  task automatic halt_clear;
    @(negedge ref_clk);
    stop = 1'b1;
    @(negedge ref_clk);
    stop = 1'b0;
    clr = 3'h7;
    @(negedge ref_clk);
    clr = 3'h0;
    repeat (2) @(negedge ref_clk);
    cmp_bit("flags_clear", 1'b0, |flags);
    cmp_bit("idle", 1'b0, measuring | irq_mend | irq_ferr | irq_ovf);
  endtask : halt_clear

  task automatic t_prescale;
    int sh[4] = '{0, 2, 3, 5};
    logic [15:0] e, held;
    for (int i = 0; i < 4; i++)
    begin
      e = 16'h20 >> sh[i];
      run_chk(mk(2'(i), EDGE_RISE, e - 16'h1, e + 16'h1), e, 1'b1);
      held = count;
      repeat (300) @(negedge ref_clk);
      cmp_bit("single_stop", 1'b0, measuring);
      cmp_bit("count_held", 1'b1, count === held);
      halt_clear();
    end
  endtask : t_prescale

  task automatic t_edges;
    cam_cfg_t c;
    logic [15:0] e;
    for (int i = 1; i < 4; i++)
    begin
      e = (i == 1) ? 16'h20 : 16'h10;
      c = mk(MDIV_1, 2'(i), e, e + 16'h2);
      c.mend_ie = (i != 3);
      run_chk(c, e, 1'b1);
      halt_clear();
    end
  endtask : t_edges

  task automatic t_ferr;
    cam_cfg_t c;
    c = mk(MDIV_1, EDGE_RISE, 16'h0, 16'h14);
    c.ferr_ie = 1'b0;
    run_chk(c, 16'h20, 1'b0);
    halt_clear();
    run_chk(mk(MDIV_1, EDGE_RISE, 16'h28, 16'h3C), 16'h20, 1'b0);
    halt_clear();
  endtask : t_ferr

  task automatic t_sticky;
    run_chk(mk(MDIV_1, EDGE_RISE, 16'h1E, 16'h20), 16'h20, 1'b1);
    @(negedge ref_clk);
    stop = 1'b1;
    @(negedge ref_clk);
    stop = 1'b0;
    clr.ferr = 1'b1;
    @(negedge ref_clk);
    clr.ferr = 1'b0;
    repeat (200) @(negedge ref_clk);
    cmp_bit("mend_sticky", 1'b1, flags.mend);
    cmp_bit("irq_sticky", 1'b1, irq_mend);
    halt_clear();
  endtask : t_sticky

  task automatic t_repeat;
    cam_cfg_t c;
    c = mk(MDIV_1, EDGE_RISE, 16'h20, 16'h22);
    c.repeat_mode = 1'b1;
    run_chk(c, 16'h20, 1'b1);
    repeat (600) @(negedge ref_clk);
    cmp_bit("repeat_run", 1'b1, measuring);
    halt_clear();
  endtask : t_repeat

  task automatic t_refsel;
    cam_cfg_t c;
    c = mk(MDIV_1, EDGE_RISE, 16'h1F, 16'h21);
    c.filt = 2'h1;
    run_chk(c, 16'h20, 1'b1);
    halt_clear();
    c.filt = 2'h2;
    run_chk(c, 16'h20, 1'b1);
    halt_clear();
    c.filt = FILT_OFF;
    c.ext_ref = 1'b0;
    run_chk(c, 16'h20, 1'b1);
    halt_clear();
    c = mk(MDIV_32, EDGE_RISE, 16'h3, 16'h5);
    c.ext_ref = 1'b0;
    c.rdiv = RDIV_128;
    run_chk(c, 16'h4, 1'b1);
    halt_clear();
  endtask : t_refsel

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    stop = 1'b0;
    clr = 3'h0;
    cfg = mk(MDIV_1, EDGE_RISE, 16'h0, 16'h0);
    error_cnt = 0;
    checks = 0;
    cycles = 0;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    t_prescale();
    t_edges();
    t_ferr();
    t_sticky();
    t_repeat();
    t_refsel();
    conclude();
  end
endmodule : test_cam_monitor
